// >>> bench/asr_core_sva.sv
// port assertions for the accelerometer spi block
`timescale 1ns/1ns
module asr_core_sva (
  input wire logic       CLK,
  input wire logic       RESETN,
  input wire logic       SCLK,
  input wire logic       SEL_N,
  input wire logic       SDO,
  input wire logic       SDO_OE,
  input wire logic [7:0] CONTROL
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  a_ctl_reset: assert property ($rose(RESETN) |-> CONTROL == 8'h00)
    else $error("control not clear after reset");
  a_oe_on: assert property ($fell(SEL_N) |-> ##[2:8] SDO_OE)
    else $error("output not enabled after select");
  a_oe_off: assert property ($rose(SEL_N) |-> ##[2:8] !SDO_OE)
    else $error("output not released after select");
  a_sel_idle: assert property (SEL_N [*8] |-> !SDO_OE)
    else $error("output driven while deselected");
  a_oe_hold: assert property ($rose(SDO_OE) |-> SDO_OE [*8])
    else $error("output enable too short");
  a_oe_sel: assert property ($rose(SDO_OE) |-> !SEL_N)
    else $error("output enabled without select");
  a_sdo_steady: assert property ((SCLK && SDO_OE) [*8] |-> $stable(SDO))
    else $error("data moved while serial clock high");
  a_ctl_frame: assert property ($changed(CONTROL) |-> SEL_N && $past(SEL_N, 2))
    else $error("control changed inside a frame");
  a_ctl_hold: assert property (SDO_OE && $past(SDO_OE) |-> $stable(CONTROL))
    else $error("control changed while driving");
  cover property ($changed(CONTROL));
  cover property ($rose(SDO_OE));
  cover property ((SCLK && SDO_OE) [*8]);
endmodule // asr_core_sva
bind asr_core asr_core_sva asr_core_sva_i (.CLK(CLK), .RESETN(RESETN), .SCLK(SCLK),
  .SEL_N(SEL_N), .SDO(SDO), .SDO_OE(SDO_OE), .CONTROL(CONTROL));

// >>> bench/asr_master.sv
// spi master model driving mode zero frames
`timescale 1ns/1ns
module asr_master (
  output logic     SCLK,
  output logic     SEL_N,
  output logic     SDI,
  input wire logic SDO
);
  initial begin
    SCLK = 1'b0;
    SEL_N = 1'b1;
    SDI = 1'b0;
  end
  // one frame of n rising edges, msb first
  task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
    rx = 16'h0000;
    SEL_N = 1'b0;
    for (int i = 0; i < n; i++) begin
      SDI = tx[15-i];
      #80 SCLK = 1'b1;
      rx = {rx[14:0], SDO};
      #80 SCLK = 1'b0;
    end
    #80 SEL_N = 1'b1;
    SDI = ~SDI;
    #80;
  endtask
endmodule // asr_master

// >>> bench/test_accel_spi_request_response.sv
// self-checking bench for the accelerometer spi block
`timescale 1ns/1ns
module test_accel_spi_request_response;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        sclk, sel_n, sdi, sdo, sdo_oe;
  logic        warm = 1'b0;
  logic [13:0] xs = 14'h3FFF;
  logic [13:0] ys = 14'h0123;
  logic [13:0] a, b;
  logic [7:0]  control, d;
  logic [15:0] pend;
  int          errors = 0;
  int          n_tests = 0;
  int          cycles = 0;
  always #4 clk = ~clk;
  asr_core asr_core_i (.CLK(clk), .RESETN(resetn), .SCLK(sclk), .SEL_N(sel_n), .SDI(sdi),
    .SDO(sdo), .SDO_OE(sdo_oe), .X_SAMPLE(xs), .YZ_SAMPLE(ys), .WARMING_FAULT(warm),
    .CONTROL(control));
  asr_master asr_master_i (.SCLK(sclk), .SEL_N(sel_n), .SDI(sdi), .SDO(sdo));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [15:0] rsp(input logic [2:0] hi, input logic [11:0] lo);
    return {hi, ~^{hi, lo}, lo};
  endfunction
  function automatic logic [15:0] sreq(input logic t, input logic [1:0] p);
    return {t, t, 1'b1, t, 8'hA5, 2'b00, p};
  endfunction
  function automatic logic [15:0] srsp(input logic t, input logic [1:0] p,
                                       input logic [13:0] s, input logic [1:0] k);
    return rsp({3{t}}, {k, p[1] ? s[13:4] : {6'h00, s[3:0]}});
  endfunction
  function automatic logic [15:0] cw(input logic [7:0] v);
    return {8'h55, v};
  endfunction
  function automatic logic [15:0] wr(input logic [7:0] v);
    return rsp(3'h2, {4'hE, v});
  endfunction
  // send a request, compare the answer to the previous one
  task automatic op(input logic [15:0] tx, input logic [15:0] nxt, input int n = 16);
    logic [15:0] rx;
    asr_master_i.xfer(tx, n, rx);
    check(rx, pend >> (16 - n));
    pend = nxt;
  endtask
  task automatic bump();
    a = xs;
    b = ys;
    xs = xs + 14'h0155;
    ys = ys - 14'h0203;
  endtask
  task automatic finish_test();
    $display("checks %0d, errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      finish_test();
    end
  end
  initial begin
    pend = rsp(3'h0, 12'hE03);
    repeat (2) @(posedge clk);
    #1 resetn = 1'b1;
    repeat (6) @(posedge clk);
    #1 check({8'h00, control}, 16'h0000);
    op(16'h0000, rsp(3'h0, 12'hE02));
    op(16'hC012, rsp(3'h0, 12'hE02));
    check({8'h00, control}, 16'h0000);
    op(cw(8'hC0), wr(8'hC0));
    op(16'h83FF, rsp(3'h4, 12'hEC0));
    op(16'h83FF, rsp(3'h0, 12'hE04), 15);
    check({8'h00, control}, 16'h00C0);
    for (int i = 0; i < 4; i++) begin
      op(sreq(i[0], i[1:0]), srsp(i[0], i[1:0], i[0] ? ys : xs, 2'h1));
    end
    bump();
    op(sreq(1'b1, 2'h2), srsp(1'b1, 2'h2, xs, 2'h1));
    for (int i = 1; i <= 2; i++) begin
      d = 8'hC0 | (8'h01 << i);
      op(cw(d), wr(d));
      op(sreq(1'b0, 2'h3), srsp(1'b0, 2'h3, ys, 2'h2));
    end
    op(cw(8'hC1), wr(8'hC1));
    op(sreq(1'b1, 2'h0), rsp(3'h7, 12'hD08));
    op(cw(8'hC0), wr(8'hC0));
    warm = 1'b1;
    op(sreq(1'b1, 2'h2), rsp(3'h7, 12'hD04));
    warm = 1'b0;
    op(cw(8'h40), wr(8'h40));
    op(sreq(1'b0, 2'h2), srsp(1'b0, 2'h2, xs, 2'h1));
    bump();
    op(sreq(1'b0, 2'h0), srsp(1'b0, 2'h0, a, 2'h1));
    op(sreq(1'b0, 2'h1), srsp(1'b0, 2'h1, ys, 2'h1));
    op(sreq(1'b0, 2'h2), srsp(1'b0, 2'h2, xs, 2'h1));
    op(cw(8'h00), wr(8'h00));
    op(sreq(1'b1, 2'h2), srsp(1'b1, 2'h2, xs, 2'h1));
    bump();
    op(sreq(1'b1, 2'h3), srsp(1'b1, 2'h3, b, 2'h1));
    op(sreq(1'b1, 2'h0), srsp(1'b1, 2'h0, a, 2'h1));
    op(sreq(1'b1, 2'h1), srsp(1'b1, 2'h1, b, 2'h1));
    op(sreq(1'b1, 2'h2), srsp(1'b1, 2'h2, xs, 2'h1));
    op(cw(8'h80), wr(8'h80));
    op(sreq(1'b0, 2'h2), srsp(1'b0, 2'h2, xs, 2'h1));
    bump();
    op(sreq(1'b0, 2'h3), srsp(1'b0, 2'h3, b, 2'h1));
    op(sreq(1'b0, 2'h2), srsp(1'b0, 2'h2, xs, 2'h1));
    op(16'h83FF, rsp(3'h4, 12'hE80));
    op(16'h83FF, rsp(3'h4, 12'hE80));
    finish_test();
  end
endmodule // test_accel_spi_request_response

// >>> design/asr_core.sv
// spi slave request decoder, response builder and channel freeze logic
//
// How it works
// - request bit 13 high means sensor read, low means control access
// - channel pick 00 x low, 01 yz low, 10 x high, 11 yz high
// - response bit 12 makes the whole sixteen-bit word odd parity
// - sensor response carries sequence tag in bits 15 to 13
// - bits 11:10 give the response kind code
// - self-test active during sensor read gives kind code 10
// - self-test code when self check enabled or temperature compensation off
// - exception bits 9:8 give the fault class code
// - exception bit 3 set when sensor read during power-down
// - exception bit 2 set when heater loop out of regulation
// - exception bits 7:4 unused, bits 1 and 0 reserved, all zero
// - sample data right-justified in bits 9:0, zero padded
// - high register gives top ten bits, low gives four bits zero padded
// - policy 00: any read freezes both until all four parts read
// - policy 01: a byte read freezes that channel until its other byte
// - policy 10: high read freezes both until other channel high read
// - policy 11: outputs update continuously, never frozen
// - control request kind 01 write, 10 read, 00 and 11 unused
// - write byte in bits 7:0, ignored on a read
// - mode zero slave: change on falling clock, sample on rising
// - sixteen bits each way per frame, msb first, select low
// - edge count other than sixteen sets frame count error bit 2
// - control register cleared to zero at reset
`timescale 1ns/1ns
module asr_core #(
  parameter int CHW = asr_pkg::CH_BITS
) (
  input  wire logic           CLK,
  input  wire logic           RESETN,
  input  wire logic           SCLK,
  input  wire logic           SEL_N,
  input  wire logic           SDI,
  output logic                SDO,
  output logic                SDO_OE,
  input  wire logic [CHW-1:0] X_SAMPLE,
  input  wire logic [CHW-1:0] YZ_SAMPLE,
  input  wire logic           WARMING_FAULT,
  output logic [7:0]          CONTROL
);
  typedef struct packed {
    logic           sclk_d;
    logic           sel_d;
    logic [7:0]     ctl;
    logic [15:0]    rsp;
    logic [CHW-1:0] x_hold;
    logic [CHW-1:0] yz_hold;
    logic           x_frz;
    logic           yz_frz;
    logic [3:0]     seen;
  } asr_core_t;

  asr_core_t st, next_st;
  logic sclk_s;
  logic sel_s;
  logic sel_act;
  logic rise;
  logic fall;
  logic start;
  logic stop;
  logic shift_out;
  logic [15:0] rx;
  logic [5:0]  ecount;

  asr_sync u_sync_clk (
    .CLK    (CLK),
    .RESETN (RESETN),
    .d      (SCLK),
    .q      (sclk_s)
  );
  // select synchronised active high so its reset value matches an idle pin
  asr_sync u_sync_sel (
    .CLK    (CLK),
    .RESETN (RESETN),
    .d      (!SEL_N),
    .q      (sel_act)
  );
  assign sel_s = !sel_act;

  // edges found on the sampled link clock, only inside a frame
  assign rise  = !st.sel_d && sclk_s && !st.sclk_d;
  assign fall  = !st.sel_d && !sclk_s && st.sclk_d;
  assign start = st.sel_d && !sel_s;
  assign stop  = !st.sel_d && sel_s;

  asr_shift #(
    .W (asr_pkg::FRAME_BITS)
  ) u_shift (
    .CLK        (CLK),
    .RESETN     (RESETN),
    .start      (start),
    .rise       (rise),
    .fall       (fall),
    .load_word  (st.rsp),
    .din        (SDI),
    .dout       (shift_out),
    .rx_word    (rx),
    .edge_count (ecount)
  );

  // set parity bit so the word has odd parity
  function automatic logic [15:0] with_parity(input logic [15:0] w);
    logic [15:0] r;
    r = w;
    r[asr_pkg::RSP_PAR_BIT] = 1'b0;
    r[asr_pkg::RSP_PAR_BIT] = ~(^r);
    return r;
  endfunction

  // pick the ten bits of one register from a channel word
  function automatic logic [9:0] reg_part(input logic [CHW-1:0] w, input logic hi);
    logic [9:0] r;
    if (hi) begin
      r = w[CHW-1 -: asr_pkg::DATA_BITS];
    end else begin
      r = {6'h00, w[3:0]};
    end
    return r;
  endfunction

  logic [1:0]  pick;
  logic        pick_hi;
  logic        pick_yz;
  logic [2:0]  tag;
  logic [9:0]  data;
  logic [15:0] built;
  logic [3:0]  seen_now;
  logic        frame_ok;

  assign pick     = rx[1:0];
  assign pick_hi  = pick[1];
  assign pick_yz  = pick[0];
  assign tag      = {rx[asr_pkg::REQ_SQ_HI], rx[asr_pkg::REQ_SQ_MID],
                     rx[asr_pkg::REQ_SQ_LO]};
  assign frame_ok = (ecount == 6'(asr_pkg::FRAME_BITS));
  assign seen_now = st.seen | (4'h1 << pick);

  always_comb begin
    next_st        = st;
    next_st.sclk_d = sclk_s;
    next_st.sel_d  = sel_s;
    data           = pick_yz ? reg_part(st.yz_hold, pick_hi) :
                               reg_part(st.x_hold, pick_hi);
    built          = st.rsp;
    // holding registers follow the filters unless frozen
    if (!st.x_frz) begin
      next_st.x_hold = X_SAMPLE;
    end
    if (!st.yz_frz) begin
      next_st.yz_hold = YZ_SAMPLE;
    end
    if (stop) begin
      if (!frame_ok) begin
        built = 16'hE00 | (16'h1 << asr_pkg::RSP_ERR_FRAME);
      end else if (rx[asr_pkg::REQ_AXIS_BIT]) begin
        built = {tag, 1'b0, 12'h000};
        if (st.ctl[asr_pkg::CTL_POWER_DOWN] || WARMING_FAULT) begin
          built[11:10] = asr_pkg::KIND_EXCEPT;
          built[9:8]   = asr_pkg::FAULT_EXCEPT;
          built[asr_pkg::RSP_ERR_POFF] = st.ctl[asr_pkg::CTL_POWER_DOWN];
          built[asr_pkg::RSP_ERR_WARM] = WARMING_FAULT;
        end else begin
          if (st.ctl[asr_pkg::CTL_SELF_CHECK] || st.ctl[asr_pkg::CTL_TEMP_OFF]) begin
            built[11:10] = asr_pkg::KIND_SELF;
          end else begin
            built[11:10] = asr_pkg::KIND_SENSOR;
          end
          built[9:0] = data;
          // freeze handling on a served channel read
          case ({st.ctl[asr_pkg::CTL_FRZ_HI], st.ctl[asr_pkg::CTL_FRZ_LO]})
            asr_pkg::FRZ_ALL_BYTES: begin
              next_st.seen = (seen_now == 4'hF) ? 4'h0 : seen_now;
              next_st.x_frz  = (seen_now != 4'hF);
              next_st.yz_frz = (seen_now != 4'hF);
            end
            asr_pkg::FRZ_CHANNEL: begin
              next_st.seen = seen_now;
              if (pick_yz) begin
                next_st.yz_frz = !(seen_now[asr_pkg::PICK_YZ_LO] &&
                                   seen_now[asr_pkg::PICK_YZ_HI]);
                if (!next_st.yz_frz) begin
                  next_st.seen[asr_pkg::PICK_YZ_LO] = 1'b0;
                  next_st.seen[asr_pkg::PICK_YZ_HI] = 1'b0;
                end
              end else begin
                next_st.x_frz = !(seen_now[asr_pkg::PICK_X_LO] &&
                                  seen_now[asr_pkg::PICK_X_HI]);
                if (!next_st.x_frz) begin
                  next_st.seen[asr_pkg::PICK_X_LO] = 1'b0;
                  next_st.seen[asr_pkg::PICK_X_HI] = 1'b0;
                end
              end
            end
            asr_pkg::FRZ_HIGH_BOTH: begin
              if (pick_hi) begin
                next_st.seen = seen_now;
                if (seen_now[asr_pkg::PICK_X_HI] && seen_now[asr_pkg::PICK_YZ_HI]) begin
                  next_st.seen   = 4'h0;
                  next_st.x_frz  = 1'b0;
                  next_st.yz_frz = 1'b0;
                end else begin
                  next_st.x_frz  = 1'b1;
                  next_st.yz_frz = 1'b1;
                end
              end
            end
            default: begin
              next_st.seen   = 4'h0;
              next_st.x_frz  = 1'b0;
              next_st.yz_frz = 1'b0;
            end
          endcase
        end
      end else begin
        // control register access
        built = {rx[15:13], 1'b0, 12'hE00};
        case (rx[asr_pkg::REQ_KIND_HI:asr_pkg::REQ_KIND_LO])
          asr_pkg::REQ_WRITE: begin
            next_st.ctl = rx[7:0];
            built[7:0]  = rx[7:0];
          end
          asr_pkg::REQ_READ: begin
            built[7:0] = st.ctl;
          end
          default: begin
            built = 16'hE00 | (16'h1 << asr_pkg::RSP_ERR_ILL);
          end
        endcase
      end
      // policy 11 or a policy change lets outputs run again
      if ({next_st.ctl[asr_pkg::CTL_FRZ_HI], next_st.ctl[asr_pkg::CTL_FRZ_LO]}
          != {st.ctl[asr_pkg::CTL_FRZ_HI], st.ctl[asr_pkg::CTL_FRZ_LO]}) begin
        next_st.seen   = 4'h0;
        next_st.x_frz  = 1'b0;
        next_st.yz_frz = 1'b0;
      end
      next_st.rsp = with_parity(built);
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      st        <= '0;
      st.sclk_d <= 1'b0;
      st.sel_d  <= 1'b1;
      st.ctl    <= asr_pkg::CTL_RESET;
      st.rsp    <= asr_pkg::RSP_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign SDO     = shift_out;
  assign SDO_OE  = !st.sel_d;
  assign CONTROL = st.ctl;
endmodule // asr_core

// >>> design/asr_pkg.sv
// constants for the accelerometer spi request and response block
package asr_pkg;
  localparam int FRAME_BITS = 16;
  localparam int CH_BITS    = 14;
  localparam int DATA_BITS  = 10;
  // request fields
  localparam int REQ_AXIS_BIT = 13;
  localparam int REQ_SQ_HI    = 15;
  localparam int REQ_SQ_MID   = 14;
  localparam int REQ_SQ_LO    = 12;
  localparam int REQ_KIND_HI  = 15;
  localparam int REQ_KIND_LO  = 14;
  localparam int REQ_SEL_HI   = 12;
  localparam int REQ_SEL_LO   = 8;
  // response fields
  localparam int RSP_PAR_BIT   = 12;
  localparam int RSP_ERR_POFF  = 3;
  localparam int RSP_ERR_WARM  = 2;
  localparam int RSP_ERR_FRAME = 2;
  localparam int RSP_ERR_ILL   = 1;
  localparam int RSP_ERR_DU    = 0;
  // response kind and fault class codes
  localparam logic [1:0] KIND_SENSOR = 2'h1;
  localparam logic [1:0] KIND_SELF   = 2'h2;
  localparam logic [1:0] KIND_EXCEPT = 2'h3;
  localparam logic [1:0] FAULT_SENSOR = 2'h0;
  localparam logic [1:0] FAULT_EXCEPT = 2'h1;
  localparam logic [1:0] FAULT_OTHER  = 2'h2;
  // control request kinds
  localparam logic [1:0] REQ_WRITE = 2'h1;
  localparam logic [1:0] REQ_READ  = 2'h2;
  // channel picks
  localparam logic [1:0] PICK_X_LO  = 2'h0;
  localparam logic [1:0] PICK_YZ_LO = 2'h1;
  localparam logic [1:0] PICK_X_HI  = 2'h2;
  localparam logic [1:0] PICK_YZ_HI = 2'h3;
  // control register bits
  localparam int CTL_POWER_DOWN = 0;
  localparam int CTL_SELF_CHECK = 1;
  localparam int CTL_TEMP_OFF   = 2;
  localparam int CTL_FRZ_LO     = 6;
  localparam int CTL_FRZ_HI     = 7;
  localparam logic [7:0] CTL_RESET = 8'h00;
  // freeze policies
  localparam logic [1:0] FRZ_ALL_BYTES = 2'h0;
  localparam logic [1:0] FRZ_CHANNEL   = 2'h1;
  localparam logic [1:0] FRZ_HIGH_BOTH = 2'h2;
  localparam logic [1:0] FRZ_NONE      = 2'h3;
  // first response after reset: illegal flag and unavailable flag
  localparam logic [15:0] RSP_RESET = 16'h0E03;
endpackage

// >>> design/asr_shift.sv
// 16-bit mode-0 serial shifter, msb first, clocked by sampled edges
`timescale 1ns/1ns
module asr_shift #(
  parameter int W = 16
) (
  input  wire logic         CLK,
  input  wire logic         RESETN,
  input  wire logic         start,
  input  wire logic         rise,
  input  wire logic         fall,
  input  wire logic [W-1:0] load_word,
  input  wire logic         din,
  output logic              dout,
  output logic [W-1:0]      rx_word,
  output logic [5:0]        edge_count
);
  typedef struct packed {
    logic [W-1:0] tx;
    logic [W-1:0] rx;
    logic [5:0]   cnt;
  } asr_shift_t;
  asr_shift_t st, next_st;
  always_comb begin
    next_st = st;
    if (start) begin
      next_st.tx  = load_word;
      next_st.cnt = 6'h00;
    end else begin
      if (rise) begin
        next_st.rx = {st.rx[W-2:0], din};
        if (st.cnt != 6'h3F) begin
          next_st.cnt = st.cnt + 6'h01;
        end
      end
      if (fall) begin
        next_st.tx = {st.tx[W-2:0], 1'b0};
      end
    end
  end
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign dout       = st.tx[W-1];
  assign rx_word    = st.rx;
  assign edge_count = st.cnt;
endmodule // asr_shift

// >>> design/asr_sync.sv
// three-stage synchroniser with second/third stage agreement
`timescale 1ns/1ns
module asr_sync (
  input  wire logic CLK,
  input  wire logic RESETN,
  input  wire logic d,
  output logic      q
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic q;
  } asr_sync_t;
  asr_sync_t st, next_st;
  always_comb begin
    next_st    = st;
    next_st.s1 = d;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    if (st.s2 == st.s3) begin
      next_st.q = st.s3;
    end
  end
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign q = st.q;
endmodule // asr_sync
